// file: hw/ims_i2c_master.v
// I2C master sequencer: AXI4-Lite registers, bus sequences and pin drivers.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defs.vh"

module ims_i2c_master #(
	parameter [7:0] HALF_TCY_CLKS = 8'h02
) (
	input wire CLOCK,
	input wire RST_N,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire SDA_I,
	output reg SDA_O,
	output reg SDA_OE,
	input wire SCL_I,
	output reg SCL_O,
	output reg SCL_OE
);

	// ======================================================================
	// Sequencer states
	// ======================================================================
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_ST1 = 4'h1;
	localparam [3:0] S_ST2 = 4'h2;
	localparam [3:0] S_RS0 = 4'h3;
	localparam [3:0] S_RS1 = 4'h4;
	localparam [3:0] S_RS2 = 4'h5;
	localparam [3:0] S_RS3 = 4'h6;
	localparam [3:0] S_TXL = 4'h7;
	localparam [3:0] S_TXH = 4'h8;
	localparam [3:0] S_RXL = 4'h9;
	localparam [3:0] S_RXH = 4'hA;
	localparam [3:0] S_AKL = 4'hB;
	localparam [3:0] S_AKH = 4'hC;
	localparam [3:0] S_SP0 = 4'hD;
	localparam [3:0] S_SP1 = 4'hE;
	localparam [3:0] S_SP2 = 4'hF;

	reg [1:0] rst_sync_r;
	wire rst_n;
	reg sda_m_r, sda_s_r, scl_m_r, scl_s_r;
	reg aw_hold_r, w_hold_r;
	reg [7:0] waddr_r;
	reg [7:0] wbyte_r;
	reg wstrb0_r;
	reg [3:0] state_r;
	reg start_req_bit, restart_req_bit, stop_req_bit;
	reg receive_req_bit, ack_seq_req_bit, ack_value_bit, ack_status_bit;
	reg buffer_full_flag, start_seen_r, stop_seen_r;
	reg write_collision_flag, receive_overflow_flag;
	reg serial_irq_flag, bus_collision_flag;
	reg [7:0] data_buffer;
	reg [7:0] shift_register;
	reg [6:0] address_reload_register;
	reg tx_go_r, rx_mode_r, armed_r, brg_load_r;
	reg [3:0] bits_r;
	reg [31:0] rd_nxt;
	wire brg_expire, tmo, wr_fire, idle_free, seq_start;

	// Reset release through two flip-flops.
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Two-stage synchronisers for the line levels.
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
		end else begin
			sda_m_r <= SDA_I;
			sda_s_r <= sda_m_r;
			scl_m_r <= SCL_I;
			scl_s_r <= scl_m_r;
		end
	end

	// ======================================================================
	// Baud rate generator
	// ======================================================================
	ims_brg #(
		.HALF_TCY_CLKS(HALF_TCY_CLKS)
	) u_brg (
		.clk(CLOCK),
		.rst_n(rst_n),
		.load(brg_load_r),
		.reload(address_reload_register),
		.expire(brg_expire)
	);

	// A time-out in the cycle after a reload belongs to the old count.
	assign tmo = brg_expire & ~brg_load_r;
	assign wr_fire = aw_hold_r & w_hold_r & ~S_AXI_BVALID;
	assign idle_free = (state_r == S_IDLE) & ~tx_go_r & ~start_req_bit &
		~restart_req_bit & ~stop_req_bit & ~receive_req_bit &
		~ack_seq_req_bit;
	assign seq_start = (state_r >= S_ST1) && (state_r <= S_RS3);

	// Read data multiplexer.
	always @* begin
		rd_nxt = 32'h00000000;
		case (S_AXI_ARADDR)
		`IMS_OFS_CTRL: begin
			rd_nxt[`IMS_C_START] = start_req_bit;
			rd_nxt[`IMS_C_RESTART] = restart_req_bit;
			rd_nxt[`IMS_C_STOP] = stop_req_bit;
			rd_nxt[`IMS_C_RECV] = receive_req_bit;
			rd_nxt[`IMS_C_ACKSEQ] = ack_seq_req_bit;
			rd_nxt[`IMS_C_ACKVAL] = ack_value_bit;
			rd_nxt[`IMS_C_ACK_STATUS_BIT] = ack_status_bit;
		end
		`IMS_OFS_STAT: begin
			rd_nxt[`IMS_S_BF] = buffer_full_flag;
			rd_nxt[`IMS_S_START] = start_seen_r;
			rd_nxt[`IMS_S_STOP] = stop_seen_r;
			rd_nxt[`IMS_S_WRITE_COLLISION_FLAG] = write_collision_flag;
			rd_nxt[`IMS_S_OVFL] = receive_overflow_flag;
			rd_nxt[`IMS_S_IRQ] = serial_irq_flag;
			rd_nxt[`IMS_S_BCOL] = bus_collision_flag;
		end
		`IMS_OFS_DATA: rd_nxt[7:0] = data_buffer;
		`IMS_OFS_RELOAD: rd_nxt[6:0] = address_reload_register;
		default: rd_nxt = 32'h00000000;
		endcase
	end

	// Bus slave, register writes and the line sequencer in one process.
	// Hardware sets are written after software clears, so a set wins.
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `IMS_RESP_OKAY;
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `IMS_RESP_OKAY;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			waddr_r <= 8'h00;
			wbyte_r <= 8'h00;
			wstrb0_r <= 1'b0;
			SDA_O <= 1'b0;
			SDA_OE <= 1'b0;
			SCL_O <= 1'b0;
			SCL_OE <= 1'b0;
			state_r <= S_IDLE;
			start_req_bit <= 1'b0;
			restart_req_bit <= 1'b0;
			stop_req_bit <= 1'b0;
			receive_req_bit <= 1'b0;
			ack_seq_req_bit <= 1'b0;
			ack_value_bit <= 1'b0;
			ack_status_bit <= 1'b0;
			buffer_full_flag <= 1'b0;
			start_seen_r <= 1'b0;
			stop_seen_r <= 1'b0;
			write_collision_flag <= 1'b0;
			receive_overflow_flag <= 1'b0;
			serial_irq_flag <= 1'b0;
			bus_collision_flag <= 1'b0;
			data_buffer <= 8'h00;
			shift_register <= 8'h00;
			address_reload_register <= `IMS_RELOAD_RST;
			tx_go_r <= 1'b0;
			rx_mode_r <= 1'b0;
			armed_r <= 1'b0;
			brg_load_r <= 1'b0;
			bits_r <= 4'h0;
		end else begin
			brg_load_r <= 1'b0;
			// Write address and data are taken in either order.
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_r <= 1'b1;
				waddr_r <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_r <= 1'b1;
				wbyte_r <= S_AXI_WDATA[7:0];
				wstrb0_r <= S_AXI_WSTRB[0];
				S_AXI_WREADY <= 1'b0;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `IMS_RESP_OKAY;
				case (waddr_r)
				`IMS_OFS_CTRL: if (wstrb0_r) begin
					ack_value_bit <= wbyte_r[`IMS_C_ACKVAL];
					if (idle_free) begin
						start_req_bit <= wbyte_r[`IMS_C_START];
						restart_req_bit <= wbyte_r[`IMS_C_RESTART];
						stop_req_bit <= wbyte_r[`IMS_C_STOP];
						receive_req_bit <= wbyte_r[`IMS_C_RECV];
						ack_seq_req_bit <= wbyte_r[`IMS_C_ACKSEQ];
					end
				end
				`IMS_OFS_STAT: if (wstrb0_r) begin
					if (wbyte_r[`IMS_S_WRITE_COLLISION_FLAG])
						write_collision_flag <= 1'b0;
					if (wbyte_r[`IMS_S_OVFL])
						receive_overflow_flag <= 1'b0;
					if (wbyte_r[`IMS_S_IRQ])
						serial_irq_flag <= 1'b0;
					if (wbyte_r[`IMS_S_BCOL])
						bus_collision_flag <= 1'b0;
				end
				`IMS_OFS_DATA: if (wstrb0_r) begin
					if (idle_free) begin
						data_buffer <= wbyte_r;
						buffer_full_flag <= 1'b1;
						tx_go_r <= 1'b1;
						rx_mode_r <= 1'b0;
					end else begin
						write_collision_flag <= 1'b1;
					end
				end
				`IMS_OFS_RELOAD: if (wstrb0_r)
					address_reload_register <= wbyte_r[6:0];
				default: S_AXI_BRESP <= `IMS_RESP_DECERR;
				endcase
			end
			// Reads answer one cycle after the address is taken.
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_nxt;
				S_AXI_RRESP <= (S_AXI_ARADDR[7:4] == 4'h0 &&
					S_AXI_ARADDR[1:0] == 2'b00) ?
					`IMS_RESP_OKAY : `IMS_RESP_DECERR;
				if (S_AXI_ARADDR == `IMS_OFS_DATA && rx_mode_r)
					buffer_full_flag <= 1'b0;
			end
			// Line sequencer; SDA_OE and SCL_OE high pull the line low.
			case (state_r)
			S_IDLE: begin
				armed_r <= 1'b0;
				if (start_req_bit) begin
					SDA_OE <= 1'b0;
					SCL_OE <= 1'b0;
					if (sda_s_r && scl_s_r) begin
						brg_load_r <= 1'b1;
						state_r <= S_ST1;
					end else begin
						bus_collision_flag <= 1'b1;
						start_req_bit <= 1'b0;
					end
				end else if (restart_req_bit) begin
					SCL_OE <= 1'b1;
					state_r <= S_RS0;
				end else if (stop_req_bit) begin
					SDA_OE <= 1'b1;
					state_r <= S_SP0;
				end else if (receive_req_bit) begin
					SCL_OE <= 1'b1;
					SDA_OE <= 1'b0;
					bits_r <= 4'h0;
					brg_load_r <= 1'b1;
					state_r <= S_RXL;
				end else if (ack_seq_req_bit) begin
					SCL_OE <= 1'b1;
					SDA_OE <= ~ack_value_bit;
					brg_load_r <= 1'b1;
					state_r <= S_AKL;
				end else if (tx_go_r) begin
					tx_go_r <= 1'b0;
					shift_register <= data_buffer;
					SCL_OE <= 1'b1;
					bits_r <= 4'h0;
					state_r <= S_TXL;
				end
			end
			S_ST1: begin
				if (!scl_s_r || !sda_s_r) begin
					bus_collision_flag <= 1'b1;
					start_req_bit <= 1'b0;
					state_r <= S_IDLE;
				end else if (tmo) begin
					SDA_OE <= 1'b1;
					start_seen_r <= 1'b1;
					stop_seen_r <= 1'b0;
					brg_load_r <= 1'b1;
					state_r <= S_ST2;
				end
			end
			S_ST2: if (tmo) begin
				start_req_bit <= 1'b0;
				serial_irq_flag <= 1'b1;
				SCL_OE <= 1'b1;
				state_r <= S_IDLE;
			end
			S_RS0: if (!scl_s_r) begin
				SDA_OE <= 1'b0;
				brg_load_r <= 1'b1;
				state_r <= S_RS1;
			end
			S_RS1: if (tmo) begin
				if (sda_s_r) begin
					SCL_OE <= 1'b0;
					state_r <= S_RS2;
				end else begin
					SCL_OE <= 1'b0;
					bus_collision_flag <= 1'b1;
					restart_req_bit <= 1'b0;
					state_r <= S_IDLE;
				end
			end
			S_RS2: begin
				if ((armed_r && !scl_s_r) || (scl_s_r && !sda_s_r)) begin
					bus_collision_flag <= 1'b1;
					restart_req_bit <= 1'b0;
					state_r <= S_IDLE;
				end else if (!armed_r && scl_s_r) begin
					armed_r <= 1'b1;
					brg_load_r <= 1'b1;
				end else if (armed_r && tmo) begin
					armed_r <= 1'b0;
					SDA_OE <= 1'b1;
					start_seen_r <= 1'b1;
					stop_seen_r <= 1'b0;
					brg_load_r <= 1'b1;
					state_r <= S_RS3;
				end
			end
			S_RS3: begin
				if (!scl_s_r) begin
					bus_collision_flag <= 1'b1;
					SDA_OE <= 1'b0;
					restart_req_bit <= 1'b0;
					state_r <= S_IDLE;
				end else if (tmo) begin
					restart_req_bit <= 1'b0;
					serial_irq_flag <= 1'b1;
					SCL_OE <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_TXL: begin
				if (!armed_r) begin
					armed_r <= 1'b1;
					SDA_OE <= (bits_r < `IMS_ACK_BIT) ?
						~shift_register[7] : 1'b0;
					brg_load_r <= 1'b1;
				end else if (tmo) begin
					armed_r <= 1'b0;
					SCL_OE <= 1'b0;
					state_r <= S_TXH;
				end
			end
			S_TXH: begin
				if (!armed_r) begin
					if (scl_s_r) begin
						armed_r <= 1'b1;
						brg_load_r <= 1'b1;
					end
				end else if (bits_r < `IMS_ACK_BIT && !SDA_OE && !sda_s_r) begin
					bus_collision_flag <= 1'b1;
					buffer_full_flag <= 1'b0;
					SCL_OE <= 1'b0;
					state_r <= S_IDLE;
				end else if (tmo) begin
					armed_r <= 1'b0;
					SCL_OE <= 1'b1;
					shift_register <= {shift_register[6:0], 1'b0};
					bits_r <= bits_r + 4'h1;
					if (bits_r == `IMS_LAST_DATA_BIT)
						buffer_full_flag <= 1'b0;
					if (bits_r == `IMS_ACK_BIT) begin
						ack_status_bit <= sda_s_r;
						serial_irq_flag <= 1'b1;
						state_r <= S_IDLE;
					end else begin
						state_r <= S_TXL;
					end
				end
			end
			S_RXL: if (tmo) begin
				SCL_OE <= 1'b0;
				state_r <= S_RXH;
			end
			S_RXH: begin
				if (!armed_r) begin
					if (scl_s_r) begin
						armed_r <= 1'b1;
						brg_load_r <= 1'b1;
						shift_register <= {shift_register[6:0], sda_s_r};
					end
				end else if (tmo) begin
					armed_r <= 1'b0;
					SCL_OE <= 1'b1;
					bits_r <= bits_r + 4'h1;
					if (bits_r == `IMS_LAST_DATA_BIT) begin
						receive_req_bit <= 1'b0;
						data_buffer <= shift_register;
						if (buffer_full_flag)
							receive_overflow_flag <= 1'b1;
						buffer_full_flag <= 1'b1;
						serial_irq_flag <= 1'b1;
						rx_mode_r <= 1'b1;
						state_r <= S_IDLE;
					end else begin
						brg_load_r <= 1'b1;
						state_r <= S_RXL;
					end
				end
			end
			S_AKL: if (tmo) begin
				SCL_OE <= 1'b0;
				state_r <= S_AKH;
			end
			S_AKH: begin
				if (!armed_r && scl_s_r) begin
					armed_r <= 1'b1;
					brg_load_r <= 1'b1;
				end else if (armed_r && tmo) begin
					SCL_OE <= 1'b1;
					ack_seq_req_bit <= 1'b0;
					serial_irq_flag <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_SP0: begin
				if (!armed_r && !sda_s_r) begin
					armed_r <= 1'b1;
					brg_load_r <= 1'b1;
				end else if (armed_r && tmo) begin
					armed_r <= 1'b0;
					SCL_OE <= 1'b0;
					state_r <= S_SP1;
				end
			end
			S_SP1: begin
				if (!armed_r && scl_s_r) begin
					armed_r <= 1'b1;
					brg_load_r <= 1'b1;
				end else if (armed_r && tmo) begin
					armed_r <= 1'b0;
					SDA_OE <= 1'b0;
					state_r <= S_SP2;
				end
			end
			S_SP2: begin
				if (!armed_r && sda_s_r && scl_s_r) begin
					armed_r <= 1'b1;
					stop_seen_r <= 1'b1;
					start_seen_r <= 1'b0;
					brg_load_r <= 1'b1;
				end else if (armed_r && tmo) begin
					stop_req_bit <= 1'b0;
					serial_irq_flag <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
			// Start/restart keep buffer writes out and flag them as write collisions.
			if (seq_start && wr_fire && waddr_r == `IMS_OFS_DATA)
				write_collision_flag <= 1'b1;
		end
	end

endmodule // ims_i2c_master

`default_nettype wire

// file: hw/ims_defs.vh
// Register map, field positions and reset values of the I2C master sequencer.
`ifndef IMS_DEFS_VH
`define IMS_DEFS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define IMS_OFS_CTRL 8'h00
`define IMS_OFS_STAT 8'h04
`define IMS_OFS_DATA 8'h08
`define IMS_OFS_RELOAD 8'h0C

// ==========================================================================
// Fields of master_control_register
// ==========================================================================
`define IMS_C_START 0
`define IMS_C_RESTART 1
`define IMS_C_STOP 2
`define IMS_C_RECV 3
`define IMS_C_ACKSEQ 4
`define IMS_C_ACKVAL 5
`define IMS_C_ACK_STATUS_BIT 6

// ==========================================================================
// Fields of port_status_register
// ==========================================================================
`define IMS_S_BF 0
`define IMS_S_START 1
`define IMS_S_STOP 2
`define IMS_S_WRITE_COLLISION_FLAG 3
`define IMS_S_OVFL 4
`define IMS_S_IRQ 5
`define IMS_S_BCOL 6

// ==========================================================================
// Reset values, bus answers and bit counts
// ==========================================================================
`define IMS_RELOAD_RST 7'h09
`define IMS_RESP_OKAY 2'h0
`define IMS_RESP_DECERR 2'h3
`define IMS_LAST_DATA_BIT 4'h7
`define IMS_ACK_BIT 4'h8

`endif

// file: hw/ims_brg.v
// Down-counting baud rate generator with a one-cycle time-out pulse.
`timescale 1ns/1ps
`default_nettype none

module ims_brg #(
	parameter [7:0] HALF_TCY_CLKS = 8'h02
) (
	input wire clk,
	input wire rst_n,
	input wire load,
	input wire [6:0] reload,
	output reg expire
);

	localparam [7:0] DIV_LAST = HALF_TCY_CLKS - 8'h01;

	reg [7:0] div_r;
	reg [6:0] cnt_r;
	reg run_r;
	wire tick;

	// Decrement pace: twice per instruction cycle.
	assign tick = (div_r == DIV_LAST);

	// Reload, count down to zero, pulse once and stop until reloaded.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			cnt_r <= 7'h00;
			run_r <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			div_r <= tick ? 8'h00 : div_r + 8'h01;
			if (load) begin
				cnt_r <= reload;
				run_r <= 1'b1;
				div_r <= 8'h00;
			end else if (run_r && tick) begin
				if (cnt_r == 7'h00) begin
					run_r <= 1'b0;
					expire <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 7'h01;
				end
			end
		end
	end

endmodule // ims_brg

`default_nettype wire

// file: test/ims_i2c_master_assertions.sv
// Port checks of the I2C master sequencer.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Checker
// ==========
module ims_i2c_master_checker (
	input wire CLOCK,
	input wire RST_N,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire SDA_O,
	input wire SCL_O,
	input wire SCL_OE
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	a_sda_only_pulls: assert property (!SDA_O)
		else $error("SDA driven high");
	a_scl_only_pulls: assert property (!SCL_O)
		else $error("SCL driven high");
	a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("Write response dropped early");
	a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("Read data dropped early");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		|=> S_AXI_RVALID)
		else $error("Read answer late");
	a_read_decerr: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		&& S_AXI_ARADDR[7:4] != 4'h0
		|=> S_AXI_RRESP == 2'h3 && S_AXI_RDATA == 32'h00000000)
		else $error("Unmapped read not refused");
	a_rdata_upper: assert property (S_AXI_RVALID
		|-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("Upper read bits set");
	a_scl_low_min: assert property ($rose(SCL_OE) |=> SCL_OE)
		else $error("SCL low phase too short");
	a_scl_high_min: assert property ($fell(SCL_OE) |=> !SCL_OE)
		else $error("SCL high phase too short");
endmodule // ims_i2c_master_checker

bind ims_i2c_master ims_i2c_master_checker ims_i2c_master_checker_i (
	.CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .SDA_O(SDA_O), .SCL_O(SCL_O),
	.SCL_OE(SCL_OE));
`default_nettype wire

// file: test/ims_slave_model.sv
// Behavioural I2C slave that acknowledges and sends bytes.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Slave
// ==========
module ims_slave_model (
	input wire logic scl,
	input wire logic ack_en,
	input wire logic rx_mode,
	input wire logic [7:0] tx_byte,
	input wire logic clr,
	output logic sda_pull
);
	logic [3:0] cnt = 4'h0;

	// Counts clock falls; the delay holds data a while past each fall.
	always @(negedge scl or posedge clr) begin
		if (clr)
			cnt <= 4'h0;
		else if (cnt != 4'hF)
			cnt <= #48 cnt + 4'h1;
	end

	// Pulls SDA for a zero data bit or an acknowledge, else releases it.
	assign sda_pull = rx_mode ? (cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]])
		: (cnt == 4'h8 && ack_en);
endmodule // ims_slave_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench of the I2C master sequencer.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Bench
// ==========
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic scl_pull = 1'b0;
	logic ack_en = 1'b0;
	logic rx_mode = 1'b0;
	logic clr = 1'b0;
	logic [7:0] sl_byte = 8'h00;
	logic [8:0] mon = 9'h0;
	logic [1:0] rsp;
	logic [31:0] rdat;
	logic [7:0] b;
	wire awready, wready, bvalid, arready, rvalid, sl_pull;
	wire sda_o, sda_oe, scl_o, scl_oe;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int miscompares = 0;
	int compares = 0;
	// Open-drain lines with pull-ups.
	wire sda_w = ~(sda_oe | sl_pull);
	wire scl_w = ~(scl_oe | scl_pull);

	// Clock and a record of SDA at each SCL rise.
	always #4 clk = ~clk;
	always @(posedge scl_w) mon <= {mon[7:0], sda_w};

	ims_i2c_master ims_i2c_master_i (.CLOCK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SDA_I(sda_w), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe));
	ims_slave_model ims_slave_model_i (.scl(scl_w), .ack_en(ack_en),
		.rx_mode(rx_mode), .tx_byte(sl_byte), .clr(clr),
		.sda_pull(sl_pull));

	// Control value expected after a byte went out.
	function automatic logic [31:0] ctl_exp(input logic a);
		return {25'h0, ~a, 6'h00};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude;
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One write; the answer is kept in rsp.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		// A random pause before bready makes the response wait on us.
		repeat ($urandom % 3) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	// One read; data and answer are kept in rdat and rsp.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		// A random pause before rready makes the read data wait on us.
		repeat ($urandom % 3) @(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdat = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// Polls the status word until the given flag is up.
	task automatic wait_st(input int f);
		int n;
		n = 0;
		rd(8'h04);
		while (rdat[f] !== 1'b1 && n < 400) begin
			rd(8'h04);
			n++;
		end
		chk("flag", rdat[f], 1'b1);
	endtask

	task automatic pulse_clr;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask

	// Watchdog far beyond the expected run.
	initial begin
		#(8 * 60000);
		miscompares++;
		conclude;
	end

	// Main sequence.
	initial begin
		void'($urandom(32'h0000DA1B));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h0C);
		chk("reload", rdat, 32'h09);
		rd(8'h40);
		chk("rd_resp", rsp, 2'h3);
		wr(8'h40, 32'hFF);
		chk("wr_resp", rsp, 2'h3);
		// Start while another party holds SCL low.
		scl_pull <= 1'b1;
		wr(8'h00, 32'h01);
		wait_st(6);
		rd(8'h00);
		chk("abort", rdat[0], 1'b0);
		scl_pull <= 1'b0;
		wr(8'h04, 32'h78);
		// Start with a buffer write and a control write issued during it; both are refused.
		wr(8'h00, 32'h01);
		wr(8'h08, 32'hA5);
		wr(8'h00, 32'h0A);
		wait_st(5);
		rd(8'h04);
		chk("start_st", rdat, 32'h2A);
		rd(8'h00);
		chk("start_ctl", rdat[4:0], 5'h00);
		chk("start_ln", {sda_w, scl_w}, 2'b00);
		wr(8'h04, 32'h78);
		rd(8'h04);
		chk("write_collision_flag_clr", rdat[3], 1'b0);
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			ack_en <= 1'($urandom);
			pulse_clr;
			wr(8'h08, {24'h0, b});
			rd(8'h04);
			chk("bf_set", rdat[0], 1'b1);
			wr(8'h08, 32'h00);
			wait_st(5);
			chk("tx_bits", mon, {b, ~ack_en});
			rd(8'h00);
			chk("ack_status_bit", rdat, ctl_exp(ack_en));
			rd(8'h04);
			chk("tx_st", {rdat[3], rdat[0]}, 2'b10);
			chk("scl_low", scl_w, 1'b0);
			wr(8'h04, 32'h78);
		end
		rx_mode <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			sl_byte <= b;
			pulse_clr;
			wr(8'h00, 32'h08);
			wr(8'h08, 32'h00);
			wait_st(5);
			rd(8'h04);
			chk("rx_st", {rdat[4], rdat[3], rdat[0]}, {i == 2, 2'b11});
			if (i == 0) begin
				rd(8'h08);
				chk("rx_byte", rdat, {24'h0, b});
				rd(8'h04);
				chk("bf_clr", rdat[0], 1'b0);
			end
			wr(8'h04, 32'h78);
		end
		rx_mode <= 1'b0;
		ack_en <= 1'b0;
		// Negative acknowledge, then repeated start and stop.
		wr(8'h00, 32'h30);
		wait_st(5);
		chk("ack_bit", mon[0], 1'b1);
		rd(8'h00);
		chk("ack_clr", rdat[4], 1'b0);
		wr(8'h04, 32'h78);
		wr(8'h00, 32'h02);
		wait_st(5);
		rd(8'h04);
		chk("rs_seen", rdat[1], 1'b1);
		rd(8'h00);
		chk("rs_clr", rdat[1], 1'b0);
		chk("rs_sda", sda_w, 1'b0);
		wr(8'h04, 32'h78);
		wr(8'h00, 32'h04);
		wait_st(5);
		rd(8'h04);
		chk("stop_seen", rdat[2], 1'b1);
		chk("idle_ln", {sda_w, scl_w}, 2'b11);
		conclude;
	end
endmodule // tb_top
`default_nettype wire
